// ==== include/pcfg_pkg.sv ====
// Purpose: Shared constants and types of the port configuration bank
// Assumes: AHB-Lite register bus, 32-bit data, one register per word
// Notes: Register indices are word numbers; byte address is index times four
package pcfg_pkg;

  // ==========================================================================
  // Register indices (byte address = index * 4)
  localparam int IDX_W = 16;
  localparam logic [15:0] IDX_PF_LATCH = 16'hff6e;
  localparam logic [15:0] IDX_PG_LATCH = 16'hff6f;
  localparam logic [15:0] IDX_PA_PU = 16'hff70;
  localparam logic [15:0] IDX_PB_PU = 16'hff71;
  localparam logic [15:0] IDX_PC_PU = 16'hff72;
  localparam logic [15:0] IDX_PD_PU = 16'hff73;
  localparam logic [15:0] IDX_PE_PU = 16'hff74;
  localparam logic [15:0] IDX_P3_DRV = 16'hff76;
  localparam logic [15:0] IDX_PA_DRV = 16'hff77;

  // ==========================================================================
  // Address layout
  localparam int ADDR_LSB = 2;
  localparam int ADDR_MSB = 17;
  localparam logic [13:0] ADDR_UPPER_ZERO = 14'h0000;
  localparam logic [1:0] HTRANS_IDLE = 2'h0;
  localparam logic [2:0] HSIZE_WORD = 3'h2;

  // ==========================================================================
  // Field widths and reset values
  localparam int W_PORT = 8;
  localparam int W_PG = 5;
  localparam int W_PA = 4;
  localparam int W_P3 = 6;
  localparam logic [7:0] RST_BYTE = 8'h00;
  localparam logic [4:0] RST_PG = 5'h00;
  localparam logic [3:0] RST_PA = 4'h0;
  localparam logic [5:0] RST_P3 = 6'h00;
  localparam logic [31:0] RST_WORD = 32'h0000_0000;

  // ==========================================================================
  // Bus front end states
  typedef enum logic [1:0] {
    PCFG_ST_IDLE = 2'b00,
    PCFG_ST_WRITE = 2'b01,
    PCFG_ST_READ_WAIT = 2'b10,
    PCFG_ST_READ_DONE = 2'b11
  } pcfg_bus_st_t;

  function automatic logic pcfg_hit(input logic [15:0] idx, input logic [15:0] target);
    return idx == target;
  endfunction : pcfg_hit

endpackage : pcfg_pkg

// ==== include/pcfg_reg_if.sv ====
// Purpose: Register access path between bus front end and register bank
// Assumes: One write strobe per accepted write, read index held during read
// Notes: Data lane is the low byte only
`timescale 1ns/1ps
interface pcfg_reg_if;
  import pcfg_pkg::*;
  logic wr_en;
  logic [IDX_W-1:0] wr_idx;
  logic [7:0] wr_data;
  logic [IDX_W-1:0] rd_idx;
  logic [7:0] rd_data;
  modport bus (output wr_en, output wr_idx, output wr_data, output rd_idx, input rd_data);
  modport regs (input wr_en, input wr_idx, input wr_data, input rd_idx, output rd_data);
endinterface : pcfg_reg_if

// ==== logic/pcfg_ahb_slave.sv ====
// Purpose: AHB-Lite slave front end of the port configuration bank
// Assumes: Single word transfers; response is always OKAY
// Notes: Writes take no wait state, reads take one
`timescale 1ns/1ps
module pcfg_ahb_slave
  import pcfg_pkg::*;
(
  input wire logic i_clk,
  input wire logic i_arst_n,
  input wire logic i_hsel,
  input wire logic [31:0] i_haddr,
  input wire logic [1:0] i_htrans,
  input wire logic i_hwrite,
  input wire logic [2:0] i_hsize,
  input wire logic [31:0] i_hwdata,
  input wire logic i_hready,
  output logic [31:0] o_hrdata,
  output logic o_hreadyout,
  output logic o_hresp,
  pcfg_reg_if.bus rif
);

  // ==========================================================================
  // Address phase capture
  pcfg_bus_st_t st;
  pcfg_bus_st_t next_st;
  logic [IDX_W-1:0] dp_idx;
  logic dp_hit;
  wire take = i_hsel && i_htrans[1] && i_hready;
  wire addr_ok = (i_haddr[31:ADDR_MSB+1] == ADDR_UPPER_ZERO) && (i_haddr[1:0] == 2'h0)
                 && (i_hsize == HSIZE_WORD);

  always_comb begin
    case (st)
      PCFG_ST_READ_WAIT: next_st = PCFG_ST_READ_DONE;
      PCFG_ST_IDLE, PCFG_ST_WRITE, PCFG_ST_READ_DONE: begin
        if (take) begin
          next_st = i_hwrite ? PCFG_ST_WRITE : PCFG_ST_READ_WAIT;
        end else begin
          next_st = PCFG_ST_IDLE;
        end
      end
      default: next_st = PCFG_ST_IDLE;
    endcase
  end

  always_ff @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      st <= PCFG_ST_IDLE;
      dp_idx <= '0;
      dp_hit <= 1'b0;
    end else begin
      st <= next_st;
      if (take && o_hreadyout) begin
        dp_idx <= i_haddr[ADDR_MSB:ADDR_LSB];
        dp_hit <= addr_ok;
      end
    end
  end

  // ==========================================================================
  // Data phase
  always_ff @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      o_hrdata <= RST_WORD;
    end else if (st == PCFG_ST_READ_WAIT) begin
      o_hrdata <= {24'h00_0000, dp_hit ? rif.rd_data : RST_BYTE};
    end
  end

  assign o_hreadyout = (st != PCFG_ST_READ_WAIT);
  assign o_hresp = 1'b0;
  assign rif.wr_en = (st == PCFG_ST_WRITE) && dp_hit;
  assign rif.wr_idx = dp_idx;
  assign rif.wr_data = i_hwdata[7:0];
  assign rif.rd_idx = dp_idx;

endmodule : pcfg_ahb_slave

// ==== logic/pcfg_top.sv ====
// Purpose: Port output latches, pull-up enables and driver controls
// Assumes: Direction and output data of ports A and 3 come from same clock
// Notes: Pad controls are registered; pad inputs are synchronised
`timescale 1ns/1ps
module pcfg_top
  import pcfg_pkg::*;
(
  input wire logic i_clk,
  input wire logic i_arst_n,
  input wire logic i_hsel,
  input wire logic [31:0] i_haddr,
  input wire logic [1:0] i_htrans,
  input wire logic i_hwrite,
  input wire logic [2:0] i_hsize,
  input wire logic [31:0] i_hwdata,
  input wire logic i_hready,
  output logic [31:0] o_hrdata,
  output logic o_hreadyout,
  output logic o_hresp,
  input wire logic [W_PA-1:0] i_pa_dir,
  input wire logic [W_PA-1:0] i_pa_data,
  input wire logic [W_PA-1:0] i_pa_pad_in,
  output logic [W_PA-1:0] o_pa_pad_out,
  output logic [W_PA-1:0] o_pa_pad_oe,
  output logic [W_PA-1:0] o_pa_pin_state,
  input wire logic [W_P3-1:0] i_p3_dir,
  input wire logic [W_P3-1:0] i_p3_data,
  input wire logic [W_P3-1:0] i_p3_pad_in,
  output logic [W_P3-1:0] o_p3_pad_out,
  output logic [W_P3-1:0] o_p3_pad_oe,
  output logic [W_P3-1:0] o_p3_pin_state,
  input wire logic [W_PORT-1:0] i_pb_dir,
  input wire logic [W_PORT-1:0] i_pc_dir,
  input wire logic [W_PORT-1:0] i_pd_dir,
  input wire logic [W_PORT-1:0] i_pe_dir,
  output logic [W_PA-1:0] o_pa_pullup_on,
  output logic [W_PORT-1:0] o_pb_pullup_on,
  output logic [W_PORT-1:0] o_pc_pullup_on,
  output logic [W_PORT-1:0] o_pd_pullup_on,
  output logic [W_PORT-1:0] o_pe_pullup_on,
  output logic [W_PORT-1:0] o_pf_out,
  output logic [W_PG-1:0] o_pg_out
);

  // ==========================================================================
  // Bus front end
  pcfg_reg_if rif ();

  pcfg_ahb_slave u_bus (
    .i_clk(i_clk),
    .i_arst_n(i_arst_n),
    .i_hsel(i_hsel),
    .i_haddr(i_haddr),
    .i_htrans(i_htrans),
    .i_hwrite(i_hwrite),
    .i_hsize(i_hsize),
    .i_hwdata(i_hwdata),
    .i_hready(i_hready),
    .o_hrdata(o_hrdata),
    .o_hreadyout(o_hreadyout),
    .o_hresp(o_hresp),
    .rif(rif.bus)
  );

  // ==========================================================================
  // Register bank
  logic [W_PORT-1:0] port_f_output_latch;
  logic [W_PG-1:0] port_g_output_latch;
  logic [W_PA-1:0] port_a_pullup_enable;
  logic [W_PORT-1:0] port_b_pullup_enable;
  logic [W_PORT-1:0] port_c_pullup_enable;
  logic [W_PORT-1:0] port_d_pullup_enable;
  logic [W_PORT-1:0] port_e_pullup_enable;
  logic [W_P3-1:0] port_3_driver_control;
  logic [W_PA-1:0] port_a_driver_control;

  wire we_pf = rif.wr_en && pcfg_hit(rif.wr_idx, IDX_PF_LATCH);
  wire we_pg = rif.wr_en && pcfg_hit(rif.wr_idx, IDX_PG_LATCH);
  wire we_pa_pu = rif.wr_en && pcfg_hit(rif.wr_idx, IDX_PA_PU);
  wire we_pb_pu = rif.wr_en && pcfg_hit(rif.wr_idx, IDX_PB_PU);
  wire we_pc_pu = rif.wr_en && pcfg_hit(rif.wr_idx, IDX_PC_PU);
  wire we_pd_pu = rif.wr_en && pcfg_hit(rif.wr_idx, IDX_PD_PU);
  wire we_pe_pu = rif.wr_en && pcfg_hit(rif.wr_idx, IDX_PE_PU);
  wire we_p3_drv = rif.wr_en && pcfg_hit(rif.wr_idx, IDX_P3_DRV);
  wire we_pa_drv = rif.wr_en && pcfg_hit(rif.wr_idx, IDX_PA_DRV);

  always_ff @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      port_f_output_latch <= RST_BYTE;
      port_g_output_latch <= RST_PG;
      port_a_pullup_enable <= RST_PA;
      port_b_pullup_enable <= RST_BYTE;
      port_c_pullup_enable <= RST_BYTE;
      port_d_pullup_enable <= RST_BYTE;
      port_e_pullup_enable <= RST_BYTE;
      port_3_driver_control <= RST_P3;
      port_a_driver_control <= RST_PA;
    end else begin
      if (we_pf) port_f_output_latch <= rif.wr_data;
      if (we_pg) port_g_output_latch <= rif.wr_data[W_PG-1:0];
      if (we_pa_pu) port_a_pullup_enable <= rif.wr_data[W_PA-1:0];
      if (we_pb_pu) port_b_pullup_enable <= rif.wr_data;
      if (we_pc_pu) port_c_pullup_enable <= rif.wr_data;
      if (we_pd_pu) port_d_pullup_enable <= rif.wr_data;
      if (we_pe_pu) port_e_pullup_enable <= rif.wr_data;
      if (we_p3_drv) port_3_driver_control <= rif.wr_data[W_P3-1:0];
      if (we_pa_drv) port_a_driver_control <= rif.wr_data[W_PA-1:0];
    end
  end

  // ==========================================================================
  // Read back; missing bits and unmapped indices give zero
  wire rs_pf = pcfg_hit(rif.rd_idx, IDX_PF_LATCH);
  wire rs_pg = pcfg_hit(rif.rd_idx, IDX_PG_LATCH);
  wire rs_pa_pu = pcfg_hit(rif.rd_idx, IDX_PA_PU);
  wire rs_pb_pu = pcfg_hit(rif.rd_idx, IDX_PB_PU);
  wire rs_pc_pu = pcfg_hit(rif.rd_idx, IDX_PC_PU);
  wire rs_pd_pu = pcfg_hit(rif.rd_idx, IDX_PD_PU);
  wire rs_pe_pu = pcfg_hit(rif.rd_idx, IDX_PE_PU);
  wire rs_p3_drv = pcfg_hit(rif.rd_idx, IDX_P3_DRV);
  wire rs_pa_drv = pcfg_hit(rif.rd_idx, IDX_PA_DRV);

  assign rif.rd_data = ({8{rs_pf}} & port_f_output_latch)
                     | ({8{rs_pg}} & {3'h0, port_g_output_latch})
                     | ({8{rs_pa_pu}} & {4'h0, port_a_pullup_enable})
                     | ({8{rs_pb_pu}} & port_b_pullup_enable)
                     | ({8{rs_pc_pu}} & port_c_pullup_enable)
                     | ({8{rs_pd_pu}} & port_d_pullup_enable)
                     | ({8{rs_pe_pu}} & port_e_pullup_enable)
                     | ({8{rs_p3_drv}} & {2'h0, port_3_driver_control})
                     | ({8{rs_pa_drv}} & {4'h0, port_a_driver_control});

  // ==========================================================================
  // Pad control; pull-up only on pins set as input
  wire [W_PA-1:0] next_pa_oe = i_pa_dir & ~(port_a_driver_control & i_pa_data);
  wire [W_P3-1:0] next_p3_oe = i_p3_dir & ~(port_3_driver_control & i_p3_data);
  wire [W_PA-1:0] next_pa_pu = port_a_pullup_enable & ~i_pa_dir;
  wire [W_PORT-1:0] next_pb_pu = port_b_pullup_enable & ~i_pb_dir;
  wire [W_PORT-1:0] next_pc_pu = port_c_pullup_enable & ~i_pc_dir;
  wire [W_PORT-1:0] next_pd_pu = port_d_pullup_enable & ~i_pd_dir;
  wire [W_PORT-1:0] next_pe_pu = port_e_pullup_enable & ~i_pe_dir;

  always_ff @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      o_pa_pad_out <= RST_PA;
      o_pa_pad_oe <= RST_PA;
      o_p3_pad_out <= RST_P3;
      o_p3_pad_oe <= RST_P3;
      o_pa_pullup_on <= RST_PA;
      o_pb_pullup_on <= RST_BYTE;
      o_pc_pullup_on <= RST_BYTE;
      o_pd_pullup_on <= RST_BYTE;
      o_pe_pullup_on <= RST_BYTE;
    end else begin
      o_pa_pad_out <= i_pa_data;
      o_pa_pad_oe <= next_pa_oe;
      o_p3_pad_out <= i_p3_data;
      o_p3_pad_oe <= next_p3_oe;
      o_pa_pullup_on <= next_pa_pu;
      o_pb_pullup_on <= next_pb_pu;
      o_pc_pullup_on <= next_pc_pu;
      o_pd_pullup_on <= next_pd_pu;
      o_pe_pullup_on <= next_pe_pu;
    end
  end

  assign o_pf_out = port_f_output_latch;
  assign o_pg_out = port_g_output_latch;

  // ==========================================================================
  // Pad input synchronisers
  logic [W_PA-1:0] pa_meta;
  logic [W_P3-1:0] p3_meta;

  always_ff @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      pa_meta <= RST_PA;
      o_pa_pin_state <= RST_PA;
      p3_meta <= RST_P3;
      o_p3_pin_state <= RST_P3;
    end else begin
      pa_meta <= i_pa_pad_in;
      o_pa_pin_state <= pa_meta;
      p3_meta <= i_p3_pad_in;
      o_p3_pin_state <= p3_meta;
    end
  end

  // ==========================================================================
  // Checks
  default clocking cb @(posedge i_clk);
  endclocking
  default disable iff (!i_arst_n);

  sequence s_wr(logic sel);
    rif.wr_en && sel;
  endsequence

  sequence s_in_mode(logic [7:0] dir);
    dir == 8'h00;
  endsequence

  sequence s_idle_reg(logic sel);
    i_arst_n && !sel;
  endsequence

  pf_latch_drive_a: assert property (
    s_wr(we_pf) |=> (o_pf_out == $past(rif.wr_data)) && $stable(o_pg_out))
    else $error("port F pins do not show written latch");

  pa_pu_low_a: assert property (
    s_wr(we_pa_pu) ##1 (i_pa_dir == 4'h0) |=> o_pa_pullup_on == $past(rif.wr_data[3:0], 2))
    else $error("port A pull-up does not follow low nibble");

  pb_pullup_a: assert property (
    s_wr(we_pb_pu) ##1 s_in_mode(i_pb_dir) |=> o_pb_pullup_on == $past(rif.wr_data, 2))
    else $error("port B pull-up does not follow register");

  pc_pullup_a: assert property (
    s_wr(we_pc_pu) ##1 s_in_mode(i_pc_dir) |=> o_pc_pullup_on == $past(rif.wr_data, 2))
    else $error("port C pull-up does not follow register");

  pd_pullup_a: assert property (
    s_wr(we_pd_pu) ##1 s_in_mode(i_pd_dir) |=> o_pd_pullup_on == $past(rif.wr_data, 2))
    else $error("port D pull-up does not follow register");

  pe_pullup_a: assert property (
    s_wr(we_pe_pu) ##1 s_in_mode(i_pe_dir) |=> o_pe_pullup_on == $past(rif.wr_data, 2))
    else $error("port E pull-up does not follow register");

  p3_pmos_off_a: assert property (
    i_arst_n |=> ((o_p3_pad_oe & $past(port_3_driver_control & i_p3_data)) == 6'h00)
      && (($past(i_p3_dir & ~port_3_driver_control) & ~o_p3_pad_oe) == 6'h00))
    else $error("port 3 driver does not follow PMOS control");

  pa_open_drain_a: assert property (
    i_arst_n |=> ((o_pa_pad_oe & $past(port_a_driver_control & i_pa_data)) == 4'h0)
      && (($past(i_pa_dir & ~port_a_driver_control) & ~o_pa_pad_oe) == 4'h0))
    else $error("port A driver does not follow PMOS control");

  unimpl_zero_a: assert property (
    (rs_pa_pu || rs_pa_drv) |-> rif.rd_data[7:4] == 4'h0)
    else $error("unimplemented bits read nonzero");

  p3_unimpl_a: assert property (
    (rs_p3_drv |-> rif.rd_data[7:6] == 2'h0) and (rs_pg |-> rif.rd_data[7:5] == 3'h0))
    else $error("unimplemented upper bits read nonzero");

  pf_hold_a: assert property (
    s_idle_reg(we_pf) |=> $stable(port_f_output_latch))
    else $error("port F latch changed without write");

  pa_pu_hold_a: assert property (
    s_idle_reg(we_pa_pu) |=> $stable(port_a_pullup_enable))
    else $error("port A pull-up changed without write");

  pb_hold_a: assert property (
    s_idle_reg(we_pb_pu) |=> $stable(port_b_pullup_enable))
    else $error("port B pull-up changed without write");

  pc_hold_a: assert property (
    s_idle_reg(we_pc_pu) |=> $stable(port_c_pullup_enable))
    else $error("port C pull-up changed without write");

  pd_hold_a: assert property (
    s_idle_reg(we_pd_pu) |=> $stable(port_d_pullup_enable))
    else $error("port D pull-up changed without write");

  pe_hold_a: assert property (
    s_idle_reg(we_pe_pu) |=> $stable(port_e_pullup_enable))
    else $error("port E pull-up changed without write");

  p3_drv_hold_a: assert property (
    s_idle_reg(we_p3_drv) |=> $stable(port_3_driver_control))
    else $error("port 3 driver control changed without write");

  pa_drv_hold_a: assert property (
    s_idle_reg(we_pa_drv) |=> $stable(port_a_driver_control))
    else $error("port A driver control changed without write");

  pf_readback_a: assert property (
    rs_pf |-> rif.rd_data == port_f_output_latch)
    else $error("port F latch read back wrong");

  pa_pu_readback_a: assert property (
    rs_pa_pu |-> rif.rd_data[3:0] == port_a_pullup_enable)
    else $error("port A pull-up read back wrong");

  pb_readback_a: assert property (
    rs_pb_pu |-> rif.rd_data == port_b_pullup_enable)
    else $error("port B pull-up read back wrong");

  pc_readback_a: assert property (
    rs_pc_pu |-> rif.rd_data == port_c_pullup_enable)
    else $error("port C pull-up read back wrong");

  pd_readback_a: assert property (
    rs_pd_pu |-> rif.rd_data == port_d_pullup_enable)
    else $error("port D pull-up read back wrong");

  pe_readback_a: assert property (
    rs_pe_pu |-> rif.rd_data == port_e_pullup_enable)
    else $error("port E pull-up read back wrong");

  p3_readback_a: assert property (
    rs_p3_drv |-> rif.rd_data[5:0] == port_3_driver_control)
    else $error("port 3 driver control read back wrong");

  pa_drv_readback_a: assert property (
    rs_pa_drv |-> rif.rd_data[3:0] == port_a_driver_control)
    else $error("port A driver control read back wrong");

  p3_pad_data_a: assert property (
    i_arst_n |=> o_p3_pad_out == $past(i_p3_data))
    else $error("port 3 pad data does not follow output data");

  pa_pad_data_a: assert property (
    i_arst_n |=> o_pa_pad_out == $past(i_pa_data))
    else $error("port A pad data does not follow output data");

  pa_pu_dir_a: assert property (
    i_arst_n |=> (o_pa_pullup_on & $past(i_pa_dir)) == 4'h0)
    else $error("port A pull-up on an output pin");

  pb_pu_dir_a: assert property (
    i_arst_n |=> (o_pb_pullup_on & $past(i_pb_dir)) == 8'h00)
    else $error("port B pull-up on an output pin");

  pc_pu_dir_a: assert property (
    i_arst_n |=> (o_pc_pullup_on & $past(i_pc_dir)) == 8'h00)
    else $error("port C pull-up on an output pin");

  pd_pu_dir_a: assert property (
    i_arst_n |=> (o_pd_pullup_on & $past(i_pd_dir)) == 8'h00)
    else $error("port D pull-up on an output pin");

  pe_pu_dir_a: assert property (
    i_arst_n |=> (o_pe_pullup_on & $past(i_pe_dir)) == 8'h00)
    else $error("port E pull-up on an output pin");

endmodule : pcfg_top

// ==== tb/pcfg_pad_model.sv ====
// Purpose: Board-side model of the port A and port 3 pin wires
// Assumes: One wire per pin, resolved from every party that drives it
// Notes: An undriven wire with no pull-up shows the inverse of its last level
`timescale 1ns/1ps
module pcfg_pad_model #(
  parameter int W = 4
) (
  input wire logic i_clk,
  input wire logic [W-1:0] i_pad_out,
  input wire logic [W-1:0] i_pad_oe,
  input wire logic [W-1:0] i_pullup_on,
  input wire logic [W-1:0] i_ext_en,
  input wire logic [W-1:0] i_ext_val,
  output logic [W-1:0] o_pad_in
);
  logic [W-1:0] last = '0;

  // ==========================================================================
  // Wire resolution
  always_comb begin
    for (int i = 0; i < W; i++) begin
      if (i_pad_oe[i]) begin
        o_pad_in[i] = i_pad_out[i];
      end else if (i_ext_en[i]) begin
        o_pad_in[i] = i_ext_val[i];
      end else if (i_pullup_on[i]) begin
        o_pad_in[i] = 1'b1;
      end else begin
        o_pad_in[i] = ~last[i];
      end
    end
  end

  // Remember only levels that something actually drove
  always @(posedge i_clk) begin
    for (int i = 0; i < W; i++) begin
      if (i_pad_oe[i] || i_ext_en[i] || i_pullup_on[i]) begin
        last[i] <= o_pad_in[i];
      end
    end
  end
endmodule : pcfg_pad_model

// ==== tb/pcfg_top_tb.sv ====
// Purpose: Self-checking bench of the port configuration bank
// Assumes: Bus hready is the slave's hreadyout
// Notes: Unimplemented bits are expected to read 0
`timescale 1ns/1ps
`define CHK(a, e) begin \
  checked++; \
  if ((a) !== (e)) begin \
    fails++; \
    $display("ERROR t=%0t got=%h exp=%h", $time, (a), (e)); \
  end \
end
module pcfg_top_tb;
  import pcfg_pkg::*;
  logic clk = 1'b0;
  logic arst_n = 1'b0;
  logic hsel = 1'b0;
  logic [31:0] haddr = '0;
  logic [1:0] htrans = HTRANS_IDLE;
  logic hwrite = 1'b0;
  logic [2:0] hsize = HSIZE_WORD;
  logic [31:0] hwdata = '0;
  logic [31:0] hrdata, rdv;
  logic hready, hresp;
  logic [3:0] pa_dir = '0, pa_data = '0, pa_ext_en = '0, pa_ext_val = '0;
  logic [3:0] pa_in, pa_out, pa_oe, pa_pin, pa_pu;
  logic [5:0] p3_dir = '0, p3_data = '0, p3_ext_en = '0, p3_ext_val = '0;
  logic [5:0] p3_in, p3_out, p3_oe, p3_pin;
  logic [7:0] pb_dir = '0, pc_dir = '0, pd_dir = '0, pe_dir = '0;
  logic [7:0] pb_pu, pc_pu, pd_pu, pe_pu, pf_out;
  logic [4:0] pg_out;
  int fails = 0;
  int checked = 0;
  logic [15:0] idx_tab [9] = '{IDX_PF_LATCH, IDX_PG_LATCH, IDX_PA_PU, IDX_PB_PU,
    IDX_PC_PU, IDX_PD_PU, IDX_PE_PU, IDX_P3_DRV, IDX_PA_DRV};
  logic [7:0] mask_tab [9] = '{8'hff, 8'h1f, 8'h0f, 8'hff, 8'hff, 8'hff, 8'hff, 8'h3f, 8'h0f};

  pcfg_top i_dut (.i_clk(clk), .i_arst_n(arst_n), .i_hsel(hsel), .i_haddr(haddr),
    .i_htrans(htrans), .i_hwrite(hwrite), .i_hsize(hsize), .i_hwdata(hwdata),
    .i_hready(hready), .o_hrdata(hrdata), .o_hreadyout(hready), .o_hresp(hresp),
    .i_pa_dir(pa_dir), .i_pa_data(pa_data), .i_pa_pad_in(pa_in), .o_pa_pad_out(pa_out),
    .o_pa_pad_oe(pa_oe), .o_pa_pin_state(pa_pin), .i_p3_dir(p3_dir), .i_p3_data(p3_data),
    .i_p3_pad_in(p3_in), .o_p3_pad_out(p3_out), .o_p3_pad_oe(p3_oe),
    .o_p3_pin_state(p3_pin), .i_pb_dir(pb_dir), .i_pc_dir(pc_dir), .i_pd_dir(pd_dir),
    .i_pe_dir(pe_dir), .o_pa_pullup_on(pa_pu), .o_pb_pullup_on(pb_pu),
    .o_pc_pullup_on(pc_pu), .o_pd_pullup_on(pd_pu), .o_pe_pullup_on(pe_pu),
    .o_pf_out(pf_out), .o_pg_out(pg_out));

  pcfg_pad_model #(.W(4)) i_pa_pads (.i_clk(clk), .i_pad_out(pa_out), .i_pad_oe(pa_oe),
    .i_pullup_on(pa_pu), .i_ext_en(pa_ext_en), .i_ext_val(pa_ext_val), .o_pad_in(pa_in));
  pcfg_pad_model #(.W(6)) i_p3_pads (.i_clk(clk), .i_pad_out(p3_out), .i_pad_oe(p3_oe),
    .i_pullup_on(6'h00), .i_ext_en(p3_ext_en), .i_ext_val(p3_ext_val), .o_pad_in(p3_in));

  always #50 clk = ~clk;

  // ==========================================================================
  // Bus and run control
  task automatic print_verdict;
    $display("Comparisons %0d, mismatches %0d", checked, fails);
    if (fails == 0 && checked > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask : print_verdict

  task automatic wait_ready;
    int n;
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (hready !== 1'b1 && n < 20);
    if (hready !== 1'b1) begin
      fails++;
      print_verdict();
    end
  endtask : wait_ready

  task automatic xfer(input logic wr, input logic [31:0] addr, input logic [7:0] wd);
    hsel <= 1'b1;
    htrans <= 2'b10;
    haddr <= addr;
    hwrite <= wr;
    hsize <= HSIZE_WORD;
    wait_ready();
    hsel <= 1'b0;
    htrans <= HTRANS_IDLE;
    hwdata <= {24'h00_0000, wd};
    wait_ready();
    rdv = hrdata;
    `CHK(hresp, 1'b0)
  endtask : xfer

  function automatic logic [31:0] ad(input logic [15:0] idx);
    return {14'h0000, idx, 2'b00};
  endfunction : ad

  task automatic wr(input logic [15:0] idx, input logic [7:0] d);
    xfer(1'b1, ad(idx), d);
  endtask : wr

  task automatic rd(input logic [15:0] idx);
    xfer(1'b0, ad(idx), 8'h00);
  endtask : rd

  // ==========================================================================
  // Scenarios
  task automatic t_reset;
    for (int i = 0; i < 9; i++) begin
      rd(idx_tab[i]);
      `CHK(rdv, RST_WORD)
    end
    `CHK(pf_out, RST_BYTE)
  endtask : t_reset

  task automatic t_rw;
    for (int i = 0; i < 9; i++) begin
      wr(idx_tab[i], 8'hff);
      rd(idx_tab[i]);
      `CHK(rdv, {24'h00_0000, mask_tab[i]})
      wr(idx_tab[i], 8'ha5);
      rd(idx_tab[i]);
      `CHK(rdv, {24'h00_0000, 8'ha5 & mask_tab[i]})
    end
    `CHK(pf_out, 8'ha5)
    `CHK(pg_out, 5'h05)
  endtask : t_rw

  task automatic t_pullup;
    pa_dir <= 4'h3;
    pb_dir <= 8'h0f;
    pc_dir <= 8'hf0;
    pd_dir <= 8'h00;
    pe_dir <= 8'hff;
    repeat (4) @(posedge clk);
    `CHK(pa_pu, 4'h4)
    `CHK(pa_pin[2], 1'b1)
    `CHK(pb_pu, 8'ha0)
    `CHK(pc_pu, 8'h05)
    `CHK(pd_pu, 8'ha5)
    `CHK(pe_pu, 8'h00)
  endtask : t_pullup

  task automatic t_drive;
    wr(IDX_PA_DRV, 8'h05);
    wr(IDX_P3_DRV, 8'h2a);
    pa_dir <= 4'hf;
    pa_data <= 4'hf;
    pa_ext_en <= 4'h5;
    p3_dir <= 6'h3f;
    p3_data <= 6'h3f;
    p3_ext_en <= 6'h2a;
    repeat (4) @(posedge clk);
    `CHK(pa_oe, 4'ha)
    `CHK(pa_out, 4'hf)
    `CHK(pa_pin, 4'ha)
    `CHK(p3_oe, 6'h15)
    `CHK(p3_pin, 6'h15)
    `CHK(p3_out, 6'h3f)
    pa_data <= 4'h0;
    pa_ext_en <= 4'h0;
    p3_data <= 6'h00;
    p3_ext_en <= 6'h00;
    repeat (4) @(posedge clk);
    `CHK(pa_oe, 4'hf)
    `CHK(pa_pin, 4'h0)
    `CHK(p3_oe, 6'h3f)
  endtask : t_drive

  task automatic t_unmapped;
    wr(16'hff75, 8'hff);
    rd(16'hff75);
    `CHK(rdv, RST_WORD)
    xfer(1'b1, ad(IDX_PF_LATCH) | 32'h0000_0001, 8'h3c);
    rd(IDX_PF_LATCH);
    `CHK(rdv, 32'h0000_00a5)
    xfer(1'b1, ad(IDX_PF_LATCH) | 32'h0004_0000, 8'h3c);
    rd(IDX_PF_LATCH);
    `CHK(rdv, 32'h0000_00a5)
  endtask : t_unmapped

  initial begin
    repeat (5) @(posedge clk);
    arst_n <= 1'b1;
    @(posedge clk);
    t_reset();
    t_rw();
    t_pullup();
    t_drive();
    t_unmapped();
    print_verdict();
  end
endmodule : pcfg_top_tb
